// ===== common/rpc_map.vh
// Register map, field layout and constants of the region protection checker
`ifndef RPC_MAP_VH
`define RPC_MAP_VH

// Sizes
`define RPC_NUM_REGIONS   8
`define RPC_IDX_W         3
`define RPC_AW            8
`define RPC_DW            32

// Register byte offsets
`define RPC_OFF_CTRL      8'h00
`define RPC_OFF_STATUS    8'h04
`define RPC_OFF_MASK      8'h08
`define RPC_OFF_INDEX     8'h0C
`define RPC_OFF_BASE      8'h10
`define RPC_OFF_ATTR      8'h14
`define RPC_OFF_COUNT     8'h18
`define RPC_OFF_FADDR     8'h1C
`define RPC_OFF_ONOFF     8'h20

// Control fields
`define RPC_CTRL_EN       0
`define RPC_CTRL_PDEF     1
`define RPC_CTRL_W        2

// Status and mask fields
`define RPC_ST_FAULT      0
`define RPC_ST_BGND       1
`define RPC_ST_W          2

// Attribute word fields
`define RPC_AT_ON         0
`define RPC_AT_SZ_LO      1
`define RPC_AT_SZ_HI      5
`define RPC_AT_SUB_LO     8
`define RPC_AT_SUB_HI     15
`define RPC_AT_AP_LO      24
`define RPC_AT_AP_HI      26
`define RPC_AT_XN         28
`define RPC_AT_KEEP       32'h170FFF3F

// Size codes: bytes = 2^(code+1)
`define RPC_SZ_MIN        5'h04
`define RPC_SZ_SUBMIN     5'h07
`define RPC_SZ_MAX        5'h1F

// Access permission codes
`define RPC_AP_NONE       3'h0
`define RPC_AP_PRW_UNO    3'h1
`define RPC_AP_PRW_URO    3'h2
`define RPC_AP_PRW_URW    3'h3
`define RPC_AP_PRO_UNO    3'h5
`define RPC_AP_PRO_URO    3'h6

// Base keeps bits above the 32-byte granule
`define RPC_BASE_KEEP     32'hFFFFFFE0

// Reset values
`define RPC_RST_WORD      32'h00000000
`define RPC_RST_CTRL      2'h0
`define RPC_RST_ST        2'h0

`endif

// ===== src/rpc_region.v
// Address match of one protection region with sub-region holes
`timescale 1ns/1ps
`include "rpc_map.vh"

module rpc_region (
  // Region configuration
  input  wire [31:0] base_i,
  input  wire [31:0] attr_i,
  // Access address
  input  wire [31:0] addr_i,
  // Match result
  output wire        hit_o
);

  wire [4:0]  sz;
  wire [32:0] span;
  wire [31:0] hi_mask;
  wire [31:0] sub_sh;
  wire [2:0]  sub_idx;
  wire        in_range;
  wire        sub_on;
  wire        hole;

  // Region covers 2^(code+1) bytes
  assign sz       = attr_i[`RPC_AT_SZ_HI:`RPC_AT_SZ_LO];
  assign span     = (33'h000000001 << ({28'h0000000, sz} + 33'h000000001)) - 33'h000000001;
  assign hi_mask  = ~span[31:0];
  assign in_range = ((addr_i ^ base_i) & hi_mask) == 32'h00000000;

  // Sub-region is one eighth of the region
  assign sub_sh  = addr_i >> ({27'h0000000, sz} - 32'h00000002);
  assign sub_idx = sub_sh[2:0];
  assign sub_on  = (sz >= `RPC_SZ_SUBMIN);
  assign hole    = sub_on && attr_i[`RPC_AT_SUB_LO + sub_idx];

  // Disabled regions never match
  assign hit_o = attr_i[`RPC_AT_ON] && in_range && !hole;

endmodule

// ===== src/rpc_perm.v
// Permission check of one access against the winning region attributes
`timescale 1ns/1ps
`include "rpc_map.vh"

module rpc_perm (
  // Region attributes
  input  wire [2:0] ap_i,
  input  wire       xn_i,
  // Access kind
  input  wire       priv_i,
  input  wire       write_i,
  input  wire       fetch_i,
  // Verdict
  output reg        allow_o
);

  reg rd_ok;
  reg wr_ok;

  // Decode the five read/write combinations, others deny all
  always @* begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (ap_i)
      `RPC_AP_PRW_UNO: begin
        rd_ok = priv_i;
        wr_ok = priv_i;
      end
      `RPC_AP_PRW_URO: begin
        rd_ok = 1'b1;
        wr_ok = priv_i;
      end
      `RPC_AP_PRW_URW: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      `RPC_AP_PRO_UNO: begin
        rd_ok = priv_i;
      end
      `RPC_AP_PRO_URO: begin
        rd_ok = 1'b1;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    // Fetch needs read right and execute right
    if (fetch_i)
      allow_o = rd_ok && !xn_i;
    else if (write_i)
      allow_o = wr_ok;
    else
      allow_o = rd_ok;
  end

endmodule

// ===== src/rpc_checker.v
// Region protection checker: region store, access check, fault status
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "rpc_map.vh"

module rpc_checker (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // Core access
  input  wire        acc_valid_i,
  input  wire [31:0] acc_addr_i,
  input  wire        acc_write_i,
  input  wire        acc_fetch_i,
  input  wire        acc_priv_i,
  // Fault and interrupt
  output wire        fault_o,
  output wire        irq_o
);

  // Region store
  reg  [31:0] base_mem [0:`RPC_NUM_REGIONS-1];
  reg  [31:0] attr_mem [0:`RPC_NUM_REGIONS-1];

  // Software state
  reg  [1:0]  ctrl;
  reg  [1:0]  status;
  reg  [1:0]  mask;
  reg  [2:0]  region_index;
  reg  [31:0] fault_addr;

  // Check results
  wire [7:0]  hit;
  reg         any_hit;
  reg  [2:0]  win;
  wire        allow;
  reg         next_fault;
  reg  [1:0]  next_status;
  reg  [31:0] next_rdata;

  // Decoded register strobes
  wire        wr_ctrl;
  wire        wr_mask;
  wire        wr_index;
  wire        wr_base;
  wire        wr_attr;
  wire        wr_onoff;
  wire        rd_status;

  // Selected and winning region words
  wire [31:0] sel_base;
  wire [31:0] sel_attr;
  wire [31:0] win_attr;

  // Fault events of this cycle
  wire [1:0]  event_bits;

  integer     i;
  integer     j;
  genvar      g;

  // Size code field of an attribute word
  function [4:0] size_field;
    input [31:0] w;
    begin
      size_field = w[`RPC_AT_SZ_HI:`RPC_AT_SZ_LO];
    end
  endfunction

  // Zero-extend a two-bit software register to a bus word
  function [31:0] pad_two;
    input [1:0] v;
    begin
      pad_two = {30'h00000000, v};
    end
  endfunction

  // Clamp the size code to the 32-byte floor on write
  function [31:0] fix_attr;
    input [31:0] w;
    reg   [31:0] m;
    begin
      m = w & `RPC_AT_KEEP;
      if (size_field(m) < `RPC_SZ_MIN)
        m[`RPC_AT_SZ_HI:`RPC_AT_SZ_LO] = `RPC_SZ_MIN;
      fix_attr = m;
    end
  endfunction

  // Register decode of one offset
  function sel;
    input [7:0] a;
    input [7:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // One strobe per writable register plus the status read; unmapped offsets match none
  assign wr_ctrl   = wr_i && sel(addr_i, `RPC_OFF_CTRL);
  assign wr_mask   = wr_i && sel(addr_i, `RPC_OFF_MASK);
  assign wr_index  = wr_i && sel(addr_i, `RPC_OFF_INDEX);
  assign wr_base   = wr_i && sel(addr_i, `RPC_OFF_BASE);
  assign wr_attr   = wr_i && sel(addr_i, `RPC_OFF_ATTR);
  assign wr_onoff  = wr_i && sel(addr_i, `RPC_OFF_ONOFF);
  assign rd_status = rd_i && sel(addr_i, `RPC_OFF_STATUS);

  // Array words as nets, so no process relies on array sensitivity
  assign sel_base = base_mem[region_index];
  assign sel_attr = attr_mem[region_index];
  assign win_attr = attr_mem[win];

  // One matcher per region, all in parallel
  generate
    for (g = 0; g < `RPC_NUM_REGIONS; g = g + 1) begin : g_rgn
      rpc_region u_region (
        .base_i (base_mem[g]),
        .attr_i (attr_mem[g]),
        .addr_i (acc_addr_i),
        .hit_o  (hit[g])
      );
    end
  endgenerate

  // Priority pick: later regions override earlier ones
  always @* begin
    any_hit = 1'b0;
    win     = 3'h0;
    for (i = 0; i < `RPC_NUM_REGIONS; i = i + 1) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        win     = i[2:0];
      end
    end
  end

  // Permission of the winning region
  rpc_perm u_perm (
    .ap_i    (win_attr[`RPC_AT_AP_HI:`RPC_AT_AP_LO]),
    .xn_i    (win_attr[`RPC_AT_XN]),
    .priv_i  (acc_priv_i),
    .write_i (acc_write_i),
    .fetch_i (acc_fetch_i),
    .allow_o (allow)
  );

  // Fault decision in the cycle of the access
  always @* begin
    next_fault = 1'b0;
    if (acc_valid_i && ctrl[`RPC_CTRL_EN]) begin
      if (any_hit)
        next_fault = !allow;
      else
        next_fault = !(acc_priv_i && ctrl[`RPC_CTRL_PDEF]);
    end
  end

  assign fault_o = next_fault;

  // Any fault, and a fault that hit no region
  assign event_bits[`RPC_ST_FAULT] = next_fault;
  assign event_bits[`RPC_ST_BGND]  = next_fault && !any_hit;

  // Sticky status: read clears, a new event wins over the clear
  always @* begin
    next_status = status;
    if (rd_status)
      next_status = `RPC_RST_ST;
    next_status = next_status | event_bits; // Set wins
  end

  assign irq_o = |(status & mask);

  // Read mux, data presented one cycle after the strobe
  always @* begin
    next_rdata = `RPC_RST_WORD;
    if (rd_i) begin
      case (addr_i)
        `RPC_OFF_CTRL:   next_rdata = pad_two(ctrl);
        `RPC_OFF_STATUS: next_rdata = pad_two(status);
        `RPC_OFF_MASK:   next_rdata = pad_two(mask);
        `RPC_OFF_INDEX:  next_rdata = {29'h00000000, region_index};
        `RPC_OFF_BASE:   next_rdata = sel_base;
        `RPC_OFF_ATTR:   next_rdata = sel_attr;
        `RPC_OFF_COUNT:  next_rdata = `RPC_NUM_REGIONS;
        `RPC_OFF_FADDR:  next_rdata = fault_addr;
        `RPC_OFF_ONOFF:  next_rdata = {31'h00000000, sel_attr[`RPC_AT_ON]};
        default:         next_rdata = `RPC_RST_WORD;
      endcase
    end
  end

  // Control, status and read data flops
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl         <= `RPC_RST_CTRL;
      status       <= `RPC_RST_ST;
      mask         <= `RPC_RST_ST;
      region_index <= 3'h0;
      fault_addr   <= `RPC_RST_WORD;
      rdata_o      <= `RPC_RST_WORD;
    end else begin
      status  <= next_status;
      rdata_o <= next_rdata;
      if (next_fault)
        fault_addr <= acc_addr_i;
      if (wr_ctrl)
        ctrl <= wdata_i[`RPC_CTRL_W-1:0];
      if (wr_mask)
        mask <= wdata_i[`RPC_ST_W-1:0];
      if (wr_index)
        region_index <= wdata_i[`RPC_IDX_W-1:0];
    end
  end

  // Region store writes; enable bit travels with the attributes
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (j = 0; j < `RPC_NUM_REGIONS; j = j + 1) begin
        base_mem[j] <= `RPC_RST_WORD;
        attr_mem[j] <= {26'h0000000, `RPC_SZ_MIN, 1'b0};
      end
    end else begin
      if (wr_base)
        base_mem[region_index] <= wdata_i & `RPC_BASE_KEEP;
      if (wr_attr)
        attr_mem[region_index] <= fix_attr(wdata_i);
      if (wr_onoff)
        attr_mem[region_index][`RPC_AT_ON] <= wdata_i[`RPC_AT_ON];
    end
  end

endmodule

// ===== dv/rpc_checker_chk.sv
// Port assertions of the region protection checker
`timescale 1ns/1ps
module rpc_checker_chk (
  // Clock, reset and register port
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Access port and results
  input wire logic        acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic        acc_write_i,
  input wire logic        acc_fetch_i,
  input wire logic        acc_priv_i,
  input wire logic        fault_o,
  input wire logic        irq_o
);
  logic       en_q;
  logic [1:0] msk_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Shadow of unit enable and interrupt mask
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= 1'b0;
      msk_q <= 2'h0;
    end else if (wr_i && addr_i == 8'h00) begin
      en_q <= wdata_i[0];
    end else if (wr_i && addr_i == 8'h08) begin
      msk_q <= wdata_i[1:0];
    end
  end
  a_fault_needs_acc: assert property (!acc_valid_i |-> !fault_o)
    else $error("fault without access");
  a_unit_off_quiet: assert property (!en_q |-> !fault_o)
    else $error("fault while unit off");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_status_set: assert property (fault_o ##1 !(rd_i && addr_i == 8'h04)
    ##1 (rd_i && addr_i == 8'h04) |=> rdata_o[0])
    else $error("fault not in status");
  a_status_clears: assert property ((rd_i && addr_i == 8'h04 && !fault_o) ##1 !fault_o
    ##1 (rd_i && addr_i == 8'h04 && !fault_o) |=> rdata_o == 32'h0)
    else $error("status not cleared by read");
  a_fault_addr: assert property (fault_o ##1 !fault_o ##1 (rd_i && addr_i == 8'h1C && !fault_o)
    |=> rdata_o == $past(acc_addr_i, 3))
    else $error("fault address wrong");
  a_irq_follows: assert property (fault_o && msk_q[0] && !wr_i |=> irq_o)
    else $error("unmasked fault gave no interrupt");
  a_irq_masked: assert property (msk_q == 2'h0 |-> !irq_o)
    else $error("interrupt while masked");
endmodule
bind rpc_checker rpc_checker_chk u_chk (.*);

// ===== dv/rpc_core_model.sv
// Core model issuing register cycles and memory accesses
`timescale 1ns/1ps
module rpc_core_model (
  // Clock
  input  wire logic   clk_i,
  // Register port
  output logic [7:0]  addr_o,
  output logic [31:0] wdata_o,
  output logic        wr_o,
  output logic        rd_o,
  // Access port
  output logic        acc_valid_o,
  output logic [31:0] acc_addr_o,
  output logic        acc_write_o,
  output logic        acc_fetch_o,
  output logic        acc_priv_o
);
  // Idle bus at time zero
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
    {acc_valid_o, acc_addr_o, acc_write_o, acc_fetch_o, acc_priv_o} = '0;
  end
  // One register cycle; released data is scrambled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // One access, kind is {priv, fetch, write}
  task automatic acc(input logic [31:0] a, input logic [2:0] k);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_addr_o <= a;
    {acc_priv_o, acc_fetch_o, acc_write_o} <= k;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    acc_addr_o <= ~a;
  endtask
  // Program a region: switched off first, base aligned to its size
  task automatic set_region(input logic [2:0] i, input logic [31:0] b, input logic [31:0] at);
    bus(1'b1, 8'h0C, {29'h0, i});
    bus(1'b1, 8'h20, 32'h0);
    bus(1'b1, 8'h10, b & ~((32'h2 << at[5:1]) - 32'h1));
    bus(1'b1, 8'h14, at);
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking testbench of the region protection checker
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rd_seen = 1'b0;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] exp_rd[$];
  logic exp_fault[$];
  logic [39:0] rst_tab[6] = '{40'h0000000000, 40'h0400000000, 40'h0800000000,
                              40'h1400000008, 40'h1800000008, 40'h2400000000};
  logic [2:0] aps[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  wire logic [31:0] wdata_i, rdata_o, acc_addr_i;
  wire logic [7:0]  addr_i;
  wire logic        wr_i, rd_i, acc_valid_i, acc_write_i, acc_fetch_i, acc_priv_i;
  wire logic        fault_o, irq_o;
  rpc_checker u_rpc_checker (.*);
  rpc_core_model u_rpc_core_model (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .acc_valid_o(acc_valid_i), .acc_addr_o(acc_addr_i),
    .acc_write_o(acc_write_i), .acc_fetch_o(acc_fetch_i), .acc_priv_o(acc_priv_i));
  always #5 clk_i = ~clk_i;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One compare per kind of result
  task automatic chk_rdata(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask
  task automatic chk_fault(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    u_rpc_core_model.bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_rpc_core_model.bus(1'b1, a, d);
  endtask
  task automatic ac(input logic [31:0] a, input logic [2:0] k, input logic f);
    exp_fault.push_back(f);
    u_rpc_core_model.acc(a, k);
  endtask
  // Expected rights per permission code
  function automatic logic perm_ok(input logic [2:0] ap, input logic p, input logic w);
    if (p) return w ? (ap inside {1, 2, 3}) : (ap inside {1, 2, 3, 5, 6});
    return w ? (ap == 3'h3) : (ap inside {2, 3, 6});
  endfunction
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Result monitor: oldest note against what appears
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i) begin
    if (rd_seen) chk_rdata(rdata_o, exp_rd.pop_front());
    if (acc_valid_i) chk_fault(fault_o, exp_fault.pop_front());
  end
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic [31:0] b;
    void'($urandom(32'hA8C6A105));
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (rst_tab[i]) rd(rst_tab[i][39:32], rst_tab[i][31:0]);
    for (int i = 0; i < 4; i++) ac($urandom, 3'($urandom), 1'b0);
    b = $urandom & 32'hFFFFF000;
    u_rpc_core_model.set_region(3'h0, 32'h0, 32'h0300003F);
    u_rpc_core_model.set_region(3'h1, b, 32'h16000417);
    rd(8'h10, b);
    rd(8'h14, 32'h16000417);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    ac(b + 32'h20, 3'b001, 1'b1);
    #1 chk_irq(irq_o, 1'b1);
    rd(8'h04, 32'h1);
    rd(8'h04, 32'h0);
    #1 chk_irq(irq_o, 1'b0);
    ac(b + 32'h20, 3'b110, 1'b1);
    rd(8'h1C, b + 32'h20);
    ac(b + 32'h20, 3'b000, 1'b0);
    ac(b + 32'h5FC, 3'b001, 1'b0);
    ac(b + 32'h5FC, 3'b010, 1'b0);
    foreach (aps[j]) begin
      u_rpc_core_model.set_region(3'h2, b, {5'h0, aps[j], 24'h00FF09});
      for (int k = 0; k < 4; k++) ac(b + 32'h4, {k[1], 1'b0, k[0]}, !perm_ok(aps[j], k[1], k[0]));
    end
    wr(8'h0C, 32'h1);
    wr(8'h20, 32'h0);
    ac(b + 32'h20, 3'b001, 1'b0);
    rd(8'h14, 32'h16000416);
    wr(8'h0C, 32'h3);
    wr(8'h14, 32'h00000100);
    rd(8'h14, 32'h00000108);
    wr(8'h20, 32'h1);
    rd(8'h20, 32'h1);
    rd(8'h0C, 32'h3);
    wr(8'h20, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h20, 32'h0);
    ac(b + 32'h100, 3'b100, 1'b1);
    wr(8'h00, 32'h3);
    ac(b + 32'h100, 3'b100, 1'b0);
    ac(b + 32'h100, 3'b000, 1'b1);
    repeat (2) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
